// ### rtl/ttf_pkg.sv
/*
  Shared constants for the tributary framer control block: register
  indices, field positions, reset values and frame layout figures.
  Assumes a single 250 MHz clock domain.
*/
package ttf_pkg;
  typedef enum logic [1:0] {TTF_T3, TTF_E3, TTF_G747} ttf_mode_t;
  // register indices; byte address is index times four
  localparam logic [7:0] IDX_MASTER = 8'h00;
  localparam logic [7:0] IDX_CR1 = 8'h30;
  localparam logic [7:0] IDX_CR2 = 8'h32;
  localparam logic [7:0] IDX_SR1 = 8'h34;
  localparam logic [7:0] IDX_SR2 = 8'h36;
  localparam logic [7:0] IDX_CFG = 8'h38;
  localparam logic [7:0] IDX_LTX1 = 8'h40;
  localparam logic [7:0] IDX_LTX2 = 8'h41;
  localparam logic [7:0] IDX_LRX1 = 8'h42;
  localparam logic [7:0] IDX_LRX2 = 8'h43;
  localparam int CR_AIS_LSB = 8;
  localparam int CR_NAT_LSB = 8;
  localparam int SR_EN_BIT = 7;
  localparam int SR_HI_LSB = 8;
  localparam int SR2_SOF_LSB = 12;
  localparam int LS_STREAMS = 28;
  localparam logic [15:0] LS_RST = 16'hFFFF;
  localparam logic [6:0] CR_RST = 7'h00;
  localparam logic [15:0] IDENT_CODE = 16'h00A5; // arbitrary value
  // frame layout, bit positions counted from zero
  localparam logic [10:0] LEN_T2 = 11'd1176;
  localparam logic [10:0] LEN_E2 = 11'd848;
  localparam logic [10:0] LEN_G747 = 11'd612;
  localparam logic [9:0] FAS_E2 = 10'h3D0;
  localparam logic [9:0] FAS_G747 = 10'h1D0;
  localparam logic [3:0] WLEN_E2 = 4'd10;
  localparam logic [3:0] WLEN_G747 = 4'd9;
  localparam logic [10:0] POS_X_T2 = 11'd1;
  localparam logic [10:0] POS_RAI_E2 = 11'd10;
  localparam logic [10:0] POS_NAT_E2 = 11'd11;
  localparam logic [10:0] POS_RAI_G747 = 11'd168;
  localparam logic [2:0] BURST_FRAMES = 3'd4;
  localparam logic [2:0] MISS_LIMIT = 3'd4;
endpackage

// ### rtl/ttf_formatter.sv
/*
  One tributary transmit formatter: builds framing overhead, alarm and
  national bits around the payload and injects framing error bursts.
  Assumes bit_en_i pulses once per tributary bit.
*/
`timescale 1ns/1ns
`default_nettype none
module ttf_formatter import ttf_pkg::*; (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic bit_en_i,
  input wire ttf_mode_t mode_i,
  input wire logic payload_i,
  input wire logic rai_i,
  input wire logic ais_i,
  input wire logic inject_i,
  input wire logic nat_i,
  output logic line_o
);
  logic [10:0] pos;
  logic inj_q;
  logic pending;
  logic [2:0] burst;
  logic [10:0] len;
  logic next_bit;
  logic bad;

  assign len = (mode_i == TTF_T3) ? LEN_T2 : (mode_i == TTF_E3) ? LEN_E2 : LEN_G747;
  assign bad = (burst != 3'd0);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pos <= 11'd0;
    end else if (bit_en_i) begin
      pos <= (pos >= len - 11'd1) ? 11'd0 : pos + 11'd1;
    end
  end

  // edge caught here so a short pulse still yields a whole burst
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inj_q <= 1'b0;
      pending <= 1'b0;
      burst <= 3'd0;
    end else begin
      inj_q <= inject_i;
      if (inject_i && !inj_q) begin
        pending <= 1'b1;
      end
      if (bit_en_i && pos >= len - 11'd1) begin
        if (bad) begin
          burst <= burst - 3'd1;
        end else if (pending || (inject_i && !inj_q)) begin
          burst <= BURST_FRAMES;
          pending <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    next_bit = payload_i;
    case (mode_i)
      TTF_T3: begin
        if (pos == 11'd0) next_bit = ~bad;
        if (pos == POS_X_T2) next_bit = ~rai_i;
      end
      TTF_E3: begin
        if (pos < 11'(WLEN_E2)) next_bit = FAS_E2[4'd9 - pos[3:0]] ^ bad;
        if (pos == POS_RAI_E2) next_bit = rai_i;
        if (pos == POS_NAT_E2) next_bit = nat_i;
      end
      TTF_G747: begin
        if (pos < 11'(WLEN_G747)) next_bit = FAS_G747[4'd8 - pos[3:0]] ^ bad;
        if (pos == POS_RAI_G747) next_bit = rai_i;
      end
      default: next_bit = payload_i;
    endcase
    if (ais_i) next_bit = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_o <= 1'b1;
    end else if (bit_en_i) begin
      line_o <= next_bit;
    end
  end
endmodule
`default_nettype wire

// ### rtl/ttf_receiver.sv
/*
  One tributary receive framer: finds the alignment word, tracks the
  frame, reports loss of frame, AIS, remote alarm and the national bit.
  Assumes bit_en_i pulses once per received bit.
*/
`timescale 1ns/1ns
`default_nettype none
module ttf_receiver import ttf_pkg::*; (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic bit_en_i,
  input wire ttf_mode_t mode_i,
  input wire logic data_i,
  input wire logic resync_i,
  output logic lof_o,
  output logic ais_o,
  output logic rai_o,
  output logic nat_o,
  output logic sof_o
);
  typedef enum logic {TTF_SEARCH, TTF_SYNC} ttf_rx_t;
  ttf_rx_t state;
  logic [9:0] win;
  logic [9:0] next_win;
  logic [10:0] pos;
  logic [10:0] len;
  logic [3:0] wlen;
  logic [2:0] miss;
  logic seen_zero;
  logic hit;

  assign next_win = {win[8:0], data_i};
  assign len = (mode_i == TTF_T3) ? LEN_T2 : (mode_i == TTF_E3) ? LEN_E2 : LEN_G747;
  assign wlen = (mode_i == TTF_T3) ? 4'd1 : (mode_i == TTF_E3) ? WLEN_E2 : WLEN_G747;
  assign hit = (mode_i == TTF_T3) ? data_i :
               (mode_i == TTF_E3) ? (next_win == FAS_E2) : (next_win[8:0] == FAS_G747[8:0]);
  assign lof_o = (state == TTF_SEARCH);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= TTF_SEARCH;
      win <= 10'h000;
      pos <= 11'd0;
      miss <= 3'd0;
    end else if (resync_i) begin
      state <= TTF_SEARCH;
      miss <= 3'd0;
    end else if (bit_en_i) begin
      win <= next_win;
      pos <= (pos >= len - 11'd1) ? 11'd0 : pos + 11'd1;
      if (state == TTF_SEARCH && hit) begin
        state <= TTF_SYNC;
        pos <= 11'(wlen);
        miss <= 3'd0;
      end else if (state == TTF_SYNC && pos == 11'(wlen) - 11'd1) begin
        miss <= hit ? 3'd0 : miss + 3'd1;
        if (!hit && miss == MISS_LIMIT - 3'd1) state <= TTF_SEARCH;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seen_zero <= 1'b0;
      ais_o <= 1'b0;
      rai_o <= 1'b0;
      nat_o <= 1'b0;
      sof_o <= 1'b0;
    end else begin
      sof_o <= bit_en_i && state == TTF_SYNC && pos == 11'd0;
      if (bit_en_i) begin
        seen_zero <= (pos >= len - 11'd1) ? 1'b0 : (seen_zero | ~data_i);
        if (pos >= len - 11'd1) ais_o <= ~(seen_zero | ~data_i);
        if (state == TTF_SYNC) begin
          if (mode_i == TTF_T3 && pos == POS_X_T2) rai_o <= ~data_i;
          if (mode_i == TTF_E3 && pos == POS_RAI_E2) rai_o <= data_i;
          if (mode_i == TTF_G747 && pos == POS_RAI_G747) rai_o <= data_i;
          if (mode_i == TTF_E3 && pos == POS_NAT_E2) nat_o <= data_i;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/ttf_framer_ctrl.sv
/*
  Tributary framer control: Avalon-MM register slave, seven transmit
  formatters, seven receive framers and the low-speed AIS forcing.
  Assumes tributary bit strobes and data are synchronous to mclk_i.
*/
// The Avalon-MM register port was left to the implementer.
// Behaviour
// - T3 mode: X bit is zero while remote alarm set, one otherwise.
// - E3 mode: bit 11 of each E2 frame carries the remote alarm.
// - G.747 mode: bit 1 of set 2 carries the remote alarm.
// - all-ones control replaces framed data with unframed ones.
// - burst starts only on a rising injection bit; host re-arms.
// - T3 burst corrupts four consecutive F bits.
// - E3 burst inverts four consecutive alignment words.
// - G.747 burst inverts four consecutive nine-bit alignment words.
// - E3 national bits follow control bits 8 to 11; else ignored.
// - reset forces all-ones on every low-speed stream, both directions.
// - receive framers find alignment and report alarms in status.
// - resync control bit makes receive framers search again.
// - received national bits readable in status register 2.
// - loss of frame latched, read clears only once condition gone.
`timescale 1ns/1ns
`default_nettype none
module ttf_framer_ctrl import ttf_pkg::*; #(
  parameter int TRIBS = 7
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [8:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [TRIBS-1:0] tx_bit_en_i,
  input wire logic [TRIBS-1:0] tx_payload_i,
  output logic [TRIBS-1:0] tx_line_o,
  input wire logic [TRIBS-1:0] rx_bit_en_i,
  input wire logic [TRIBS-1:0] rx_data_i,
  output logic [LS_STREAMS-1:0] low_speed_tx_ais_o,
  output logic [LS_STREAMS-1:0] low_speed_rx_ais_o
);
  if (TRIBS != 7) begin : g_bad_tribs
    $error("ttf_framer_ctrl serves exactly seven tributaries");
  end

  logic [6:0] tx_remote_alarm_n;
  logic [6:0] tx_all_ones_n;
  logic [6:0] tx_frame_loss_inject_n;
  logic [3:0] e2_national_bit_n;
  logic tributary_resync;
  logic [1:0] cfg_mode;
  logic mux_en;
  logic [15:0] ls_tx1, ls_tx2, ls_rx1, ls_rx2;
  logic [6:0] lof_st, ais_st, rai_st;
  logic [3:0] sof_st;
  logic ie_lof, ie_ais, ie_rai;
  logic [6:0] lof_now, ais_now, rai_now, nat_now, sof_now;
  logic [6:0] tx_line;
  ttf_mode_t mode;
  logic [7:0] idx;
  logic aligned;
  logic take;
  logic wr;
  logic rd_take;
  logic [15:0] next_rdata;

  assign mode = (cfg_mode == 2'd1) ? TTF_E3 : (cfg_mode == 2'd2) ? TTF_G747 : TTF_T3;
  assign idx = avs_address_i[8:2] == 7'h00 ? 8'h00 : {1'b0, avs_address_i[8:2]};
  assign aligned = (avs_address_i[1:0] == 2'b00);
  // requests are taken on the first cycle, answered one cycle later
  assign take = avs_waitrequest_o && (avs_read_i || avs_write_i);
  assign wr = avs_write_i && !avs_waitrequest_o && aligned;
  assign rd_take = avs_read_i && avs_waitrequest_o && aligned;

  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
    be_merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !take;
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    case (idx)
      IDX_MASTER: next_rdata = IDENT_CODE;
      IDX_CR1: next_rdata = {1'b0, tx_all_ones_n, 1'b0, tx_remote_alarm_n};
      IDX_CR2: next_rdata = {4'h0, e2_national_bit_n, 1'b0, tx_frame_loss_inject_n};
      IDX_SR1: next_rdata = {ie_ais, ais_st, ie_lof, lof_st};
      IDX_SR2: next_rdata = {sof_st, nat_now[3:0], ie_rai, rai_st};
      IDX_CFG: next_rdata = {13'h0000, mux_en, cfg_mode};
      IDX_LTX1: next_rdata = ls_tx1;
      IDX_LTX2: next_rdata = ls_tx2;
      IDX_LRX1: next_rdata = ls_rx1;
      IDX_LRX2: next_rdata = ls_rx2;
      default: next_rdata = 16'h0000;
    endcase
    if (!aligned) next_rdata = 16'h0000;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= {16'h0000, next_rdata};
    end
  end

  // control registers
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_remote_alarm_n <= CR_RST;
      tx_all_ones_n <= CR_RST;
      tx_frame_loss_inject_n <= CR_RST;
      e2_national_bit_n <= 4'h0;
      cfg_mode <= 2'd0;
      mux_en <= 1'b1;
      ie_lof <= 1'b0;
      ie_ais <= 1'b0;
      ie_rai <= 1'b0;
    end else if (wr) begin
      case (idx)
        IDX_CR1: begin
          if (avs_byteenable_i[0]) tx_remote_alarm_n <= avs_writedata_i[6:0];
          if (avs_byteenable_i[1]) tx_all_ones_n <= avs_writedata_i[CR_AIS_LSB +: 7];
        end
        IDX_CR2: begin
          if (avs_byteenable_i[0]) tx_frame_loss_inject_n <= avs_writedata_i[6:0];
          if (avs_byteenable_i[1]) e2_national_bit_n <= avs_writedata_i[CR_NAT_LSB +: 4];
        end
        IDX_SR1: begin
          if (avs_byteenable_i[0]) ie_lof <= avs_writedata_i[SR_EN_BIT];
          if (avs_byteenable_i[1]) ie_ais <= avs_writedata_i[SR_HI_LSB + SR_EN_BIT];
        end
        IDX_SR2: begin
          if (avs_byteenable_i[0]) ie_rai <= avs_writedata_i[SR_EN_BIT];
        end
        IDX_CFG: begin
          if (avs_byteenable_i[0]) begin
            cfg_mode <= (avs_writedata_i[1:0] == 2'd3) ? 2'd0 : avs_writedata_i[1:0];
            mux_en <= avs_writedata_i[2];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // resync is a one-cycle pulse on write of bit 0
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tributary_resync <= 1'b0;
    end else begin
      tributary_resync <= wr && idx == IDX_MASTER && avs_byteenable_i[0] && avs_writedata_i[0];
    end
  end

  // low-speed forcing, all ones after reset
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ls_tx1 <= LS_RST;
      ls_tx2 <= LS_RST;
      ls_rx1 <= LS_RST;
      ls_rx2 <= LS_RST;
    end else if (wr) begin
      if (idx == IDX_LTX1) ls_tx1 <= be_merge(ls_tx1, avs_writedata_i, avs_byteenable_i);
      if (idx == IDX_LTX2) ls_tx2 <= be_merge(ls_tx2, avs_writedata_i, avs_byteenable_i);
      if (idx == IDX_LRX1) ls_rx1 <= be_merge(ls_rx1, avs_writedata_i, avs_byteenable_i);
      if (idx == IDX_LRX2) ls_rx2 <= be_merge(ls_rx2, avs_writedata_i, avs_byteenable_i);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_speed_tx_ais_o <= '1;
      low_speed_rx_ais_o <= '1;
    end else begin
      low_speed_tx_ais_o <= {ls_tx2[11:0], ls_tx1};
      low_speed_rx_ais_o <= {ls_rx2[11:0], ls_rx1};
    end
  end

  // latched status; a set in the clearing cycle wins
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lof_st <= 7'h00;
      ais_st <= 7'h00;
      rai_st <= 7'h00;
      sof_st <= 4'h0;
    end else begin
      if (rd_take && idx == IDX_SR1) begin
        lof_st <= lof_now;
        ais_st <= ais_now;
      end else begin
        lof_st <= lof_st | lof_now;
        ais_st <= ais_st | ais_now;
      end
      if (rd_take && idx == IDX_SR2) begin
        rai_st <= rai_now;
        sof_st <= sof_now[3:0];
      end else begin
        rai_st <= rai_st | rai_now;
        sof_st <= sof_st | sof_now[3:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_trib
      ttf_formatter u_fmt (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .bit_en_i(tx_bit_en_i[g]),
        .mode_i(mode),
        .payload_i(tx_payload_i[g]),
        .rai_i(tx_remote_alarm_n[g]),
        .ais_i(tx_all_ones_n[g] || !mux_en),
        .inject_i(tx_frame_loss_inject_n[g] && mux_en),
        .nat_i(e2_national_bit_n[g % 4]),
        .line_o(tx_line[g])
      );
      ttf_receiver u_rx (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .bit_en_i(rx_bit_en_i[g] && mux_en),
        .mode_i(mode),
        .data_i(rx_data_i[g]),
        .resync_i(tributary_resync),
        .lof_o(lof_now[g]),
        .ais_o(ais_now[g]),
        .rai_o(rai_now[g]),
        .nat_o(nat_now[g]),
        .sof_o(sof_now[g])
      );
    end
  endgenerate

  assign tx_line_o = tx_line;

  sequence s_inj_rise;
    !tx_frame_loss_inject_n[0] ##1 tx_frame_loss_inject_n[0];
  endsequence

  chk_reset_ls_force: assert property (@(posedge mclk_i)
    $rose(nrst_i) |-> low_speed_tx_ais_o == '1 && low_speed_rx_ais_o == '1)
    else $error("low-speed streams not forced after reset");
  chk_ais_ones: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    tx_all_ones_n[1] && $past(tx_all_ones_n[1]) && $past(tx_bit_en_i[1]) |-> tx_line_o[1])
    else $error("all-ones not sent");
  chk_resync_search: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    tributary_resync |=> lof_now == 7'h7F)
    else $error("resync did not restart search");
  chk_lof_latch: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    lof_now[0] |=> lof_st[0])
    else $error("loss of frame not latched");
  chk_lof_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    lof_st[0] && !(rd_take && idx == IDX_SR1) |=> lof_st[0])
    else $error("loss of frame dropped without read");
  chk_inject_arm: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    s_inj_rise ##0 mux_en |=> g_trib[0].u_fmt.pending || g_trib[0].u_fmt.burst != 3'd0)
    else $error("injection edge missed");
  chk_burst_len: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    g_trib[0].u_fmt.burst <= BURST_FRAMES)
    else $error("burst longer than four frames");
  chk_nat_status: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    rd_take && idx == IDX_SR2 |=> avs_readdata_o[11:8] == $past(nat_now[3:0]))
    else $error("national bits not reported");
  chk_bus_answer: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    take |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// ### tb/ttf_far_end_model.sv
/*
  Far-end demultiplexer model: makes tributary bit strobes, captures the
  formatted bits by frame position, counts inverted alignment words and
  zeros, and loops the line back as receive data.
  Assumes the framer answers each strobe on the following cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module ttf_far_end_model import ttf_pkg::*; (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire ttf_mode_t mode_i,
  input wire logic [6:0] line_i,
  output logic [6:0] bit_en_o,
  output logic [6:0] payload_o,
  output logic [6:0] rx_en_o,
  output logic [6:0] rx_data_o
);
  logic stb;
  logic stb_q;
  logic [10:0] pos;
  logic [10:0] len;
  logic [3:0] wlen;
  logic [9:0] fas;
  logic [9:0] mask;
  logic [9:0] word [7];
  logic [6:0] cap [0:1175];
  int inv_cnt [7];
  int zcnt [7];
  // strobes stand still while idle, so frame positions stay aligned
  assign bit_en_o = {7{stb}};
  assign rx_en_o = {7{stb_q}};
  assign payload_o = {7{pos[1]}};
  // line counts as released between strobes: show its inverse
  assign rx_data_o = stb_q ? line_i : ~line_i;
  assign len = (mode_i == TTF_E3) ? LEN_E2 : (mode_i == TTF_G747) ? LEN_G747 : LEN_T2;
  assign wlen = (mode_i == TTF_E3) ? WLEN_E2 : (mode_i == TTF_G747) ? WLEN_G747 : 4'h1;
  assign fas = (mode_i == TTF_E3) ? FAS_E2 : (mode_i == TTF_G747) ? FAS_G747 : 10'h001;
  assign mask = (10'h001 << wlen) - 10'h001;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stb <= 1'b0;
      stb_q <= 1'b0;
      pos <= 11'h000;
    end else begin
      stb <= run_i && !stb;
      stb_q <= stb;
      if (stb_q) begin
        pos <= (pos == len - 11'h001) ? 11'h000 : pos + 11'h001;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (stb_q) begin
      cap[pos] <= line_i;
    end
  end
  // alignment word checked once it is complete in each frame
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int t = 0; t < 7; t++) begin
        inv_cnt[t] <= 0;
        zcnt[t] <= 0;
        word[t] <= 10'h000;
      end
    end else if (stb_q) begin
      for (int t = 0; t < 7; t++) begin
        zcnt[t] <= zcnt[t] + (line_i[t] ? 0 : 1);
        if (pos < 11'(wlen)) begin
          word[t] <= {word[t][8:0], line_i[t]};
        end
        if (pos == 11'(wlen) && ((word[t] ^ fas) & mask) == mask) begin
          inv_cnt[t] <= inv_cnt[t] + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/*
  Testbench for the tributary framer control: Avalon-MM read and write
  tasks, register and port checks, per-mode formatter scenarios.
  Assumes the far-end model loops tx lines back to the receivers.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top import ttf_pkg::*;;
  logic mclk_i;
  logic nrst_i;
  logic [8:0] adr;
  logic rd_s;
  logic wr_s;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic wait_s;
  logic [6:0] ten;
  logic [6:0] tpay;
  logic [6:0] tline;
  logic [6:0] ren;
  logic [6:0] rdata;
  logic [27:0] ls_tx;
  logic [27:0] ls_rx;
  logic run;
  ttf_mode_t mode;
  logic [15:0] q;
  int z1;
  int z2;
  int num_errors = 0;
  int compares = 0;
  ttf_framer_ctrl ttf_framer_ctrl_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_s), .tx_bit_en_i(ten), .tx_payload_i(tpay),
    .tx_line_o(tline), .rx_bit_en_i(ren), .rx_data_i(rdata),
    .low_speed_tx_ais_o(ls_tx), .low_speed_rx_ais_o(ls_rx));
  ttf_far_end_model fe (.mclk_i(mclk_i), .nrst_i(nrst_i), .run_i(run),
    .mode_i(mode), .line_i(tline), .bit_en_o(ten), .payload_o(tpay),
    .rx_en_o(ren), .rx_data_o(rdata));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    @(posedge mclk_i);
    adr <= {idx[6:0], 2'b00};
    wdat <= {16'h0000, d};
    wr_s <= 1'b1;
    do @(posedge mclk_i); while (wait_s !== 1'b0);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge mclk_i);
    adr <= {idx[6:0], 2'b00};
    rd_s <= 1'b1;
    do @(posedge mclk_i); while (wait_s !== 1'b0);
    q = rdat[15:0];
    rd_s <= 1'b0;
  endtask
  task automatic frames(input int n);
    repeat (n * 2 * int'(fe.len)) @(posedge mclk_i);
  endtask
  // reset between modes keeps model and formatter positions in step
  task automatic start(input ttf_mode_t m);
    run <= 1'b0;
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    mode <= m;
    wr(IDX_CFG, {13'h0000, 1'b1, 2'(m)});
    run <= 1'b1;
  endtask
  task automatic summarize;
    $display("counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk_i);
    num_errors++;
    summarize();
  end
  initial begin
    nrst_i = 1'b0;
    adr = 9'h000;
    rd_s = 1'b0;
    wr_s = 1'b0;
    wdat = 32'h00000000;
    run = 1'b0;
    mode = TTF_T3;
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    chk("ls_tx", 32'h0FFFFFFF, {4'h0, ls_tx});
    chk("ls_rx", 32'h0FFFFFFF, {4'h0, ls_rx});
    rd(IDX_CR1);
    chk("cr1_rst", 32'h0, {16'h0, q});
    rd(IDX_MASTER);
    chk("ident", {16'h0, IDENT_CODE}, {16'h0, q});
    rd(8'h20);
    chk("unmapped", 32'h0, {16'h0, q});
    wr(IDX_LTX1, 16'h0000);
    wr(IDX_LTX2, 16'h0F00);
    wr(IDX_LRX1, 16'h0000);
    wr(IDX_LRX2, 16'h0000);
    // outputs lag the register by one edge; look once they have settled
    repeat (2) @(posedge mclk_i);
    chk("ls_tx_prog", 32'h0F000000, {4'h0, ls_tx});
    chk("ls_rx_prog", 32'h0, {4'h0, ls_rx});
    $display("test reset done");
    start(TTF_T3);
    wr(IDX_CR1, 16'h0201);
    frames(2);
    chk("t3_x_rai", 32'h0, {31'h0, fe.cap[POS_X_T2][0]});
    chk("t3_x_idle", 32'h1, {31'h0, fe.cap[POS_X_T2][2]});
    z1 = fe.zcnt[1];
    z2 = fe.zcnt[2];
    frames(1);
    chk("t3_ais_zeros", 32'h0, 32'(fe.zcnt[1] - z1));
    chk("t3_data_zeros", 32'h1, {31'h0, fe.zcnt[2] > z2});
    rd(IDX_SR1);
    chk("t3_rx_ais", 32'h1, {31'h0, q[9]});
    wr(IDX_CR2, 16'h0001);
    frames(6);
    chk("t3_burst", 32'h4, 32'(fe.inv_cnt[0]));
    $display("test t3 done");
    start(TTF_E3);
    wr(IDX_CR1, 16'h0001);
    wr(IDX_CR2, 16'h0500);
    frames(2);
    chk("e3_rai_on", 32'h1, {31'h0, fe.cap[POS_RAI_E2][0]});
    chk("e3_rai_off", 32'h0, {31'h0, fe.cap[POS_RAI_E2][1]});
    chk("e3_nat", 32'h5, {28'h0, fe.cap[POS_NAT_E2][3:0]});
    chk("e3_fas_ok", 32'h0, 32'(fe.inv_cnt[0]));
    rd(IDX_SR2);
    chk("e3_rx_nat", 32'h5, {28'h0, q[11:8]});
    // clear the latch left by the initial search, so the burst must set it
    rd(IDX_SR1);
    rd(IDX_SR1);
    chk("lof_locked", 32'h0, {31'h0, q[0]});
    wr(IDX_CR2, 16'h0501);
    frames(6);
    chk("e3_burst", 32'h4, 32'(fe.inv_cnt[0]));
    chk("e3_other_trib", 32'h0, 32'(fe.inv_cnt[1]));
    rd(IDX_SR1);
    chk("lof_latched", 32'h1, {31'h0, q[0]});
    frames(3);
    rd(IDX_SR1);
    rd(IDX_SR1);
    chk("lof_cleared", 32'h0, {31'h0, q[0]});
    wr(IDX_MASTER, 16'h0001);
    frames(2);
    rd(IDX_SR1);
    chk("resync_lof", 32'h1, {31'h0, q[0]});
    $display("test e3 done");
    start(TTF_G747);
    wr(IDX_CR1, 16'h0001);
    frames(2);
    chk("g747_rai_on", 32'h1, {31'h0, fe.cap[POS_RAI_G747][0]});
    chk("g747_rai_off", 32'h0, {31'h0, fe.cap[POS_RAI_G747][1]});
    wr(IDX_CR2, 16'h0001);
    frames(6);
    chk("g747_burst", 32'h4, 32'(fe.inv_cnt[0]));
    frames(6);
    chk("g747_held", 32'h4, 32'(fe.inv_cnt[0]));
    wr(IDX_CR2, 16'h0000);
    wr(IDX_CR2, 16'h0001);
    frames(6);
    chk("g747_rearm", 32'h8, 32'(fe.inv_cnt[0]));
    $display("test g747 done");
    summarize();
  end
endmodule
`default_nettype wire
